// [hdl/pmcs_params.svh]
`ifndef PMCS_PARAMS_SVH
`define PMCS_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PMCS_CODE_W     8
`define PMCS_WORD_W     16
`define PMCS_DAC_W      11
`define PMCS_TEMP_W     8
`define PMCS_PROD_W     23
`define PMCS_MV_W       13

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define PMCS_CMD_OPERATION  8'h01
`define PMCS_CMD_CLEAR      8'h03
`define PMCS_CMD_SETPOINT   8'h21
`define PMCS_CMD_SUMMARY    8'h79
`define PMCS_CMD_THERMAL    8'h7D

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define PMCS_OP_ON_A        8'h01
`define PMCS_OP_ON_B        8'h80
`define PMCS_OP_RESET       8'h80
`define PMCS_SP_RESET       16'h1400
`define PMCS_SP_MIN         16'h0400
`define PMCS_SP_MAX         16'h55E1

// ----------------------------------------------------------------
// Reference DAC arithmetic
// ----------------------------------------------------------------
`define PMCS_DAC_MULT       7'h64
`define PMCS_DAC_SHIFT      10
`define PMCS_DAC_OFFSET     13'h0064
`define PMCS_DAC_MAX        13'h07FF
`define PMCS_DAC_AT_RESET   11'h190

// ----------------------------------------------------------------
// Thermal thresholds in degrees Celsius
// ----------------------------------------------------------------
`define PMCS_OVERTEMP_FAULT_FLAG_C     8'hA0
`define PMCS_OT_WARN_C      8'h87
`define PMCS_OT_HYST_C      8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMCS_SUM_OV         5
`define PMCS_SUM_OC_LO      4
`define PMCS_SUM_GND        3
`define PMCS_SUM_TEMP       2
`define PMCS_SUM_OUTPUT_VOLTAGE_FLAG       15
`define PMCS_SUM_OC_HI      14
`define PMCS_SUM_CCX        12
`define PMCS_SUM_PGN        11
`define PMCS_SUM_RSV_MASK   16'h27C3
`define PMCS_TH_FAULT       7
`define PMCS_TH_WARN        6
`define PMCS_TH_REL         3

`endif

// [hdl/pmcs_pkg.sv]
`include "pmcs_params.svh"

package pmcs_pkg;

  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic [`PMCS_CODE_W-1:0]  code;
    logic [`PMCS_WORD_W-1:0]  data;
  } pmcs_cmd_s;

  typedef struct packed {
    logic                     valid;
    logic                     err;
    logic [`PMCS_WORD_W-1:0]  data;
  } pmcs_rsp_s;

  typedef struct packed {
    logic en;
    logic ov;
    logic cc;
    logic peak;
    logic hiccup;
    logic gnd_short;
    logic pg;
  } pmcs_cond_s;

  typedef struct packed {
    logic ov;
    logic oc;
    logic gnd;
    logic output_voltage_flag;
    logic ccx;
    logic otf;
    logic otw;
    logic otr;
  } pmcs_flags_s;

  typedef struct packed {
    pmcs_cond_s               sync1;
    pmcs_cond_s               sync2;
    logic                     cc_prev;
    logic                     hic_seen;
    logic                     warn_live;
    logic [`PMCS_CODE_W-1:0]  op;
    logic [`PMCS_WORD_W-1:0]  sp;
    pmcs_flags_s              flg;
    logic                     alert;
    logic                     conv_on;
    logic [`PMCS_DAC_W-1:0]   dac;
    pmcs_rsp_s                rsp;
  } pmcs_state_s;

endpackage

// [hdl/pmcs_regs.sv]
// Notes on behaviour
// - Writing 01h or 80h turns output on.
// - Enable pin overrides the on/off command.
// - Fault clear empties all latched status bits except edge events of its own cycle.
// - Fault clear also drops the alert output, unless an edge event sets a flag in the same cycle.
// - Persisting fault sets again, alerts again.
// - Fault clear is write only, never read.
// - Setpoint is 16-bit unsigned, 2^-10 V LSB.
// - Setpoint outside 1V..21.47V flags voltage abnormal.
// - Setpoint drives 11-bit reference DAC code.
// - Summary read returns two bytes, low first.
// - Low bit 5 marks output over-voltage.
// - Low bit 4 marks current limit or hiccup.
// - Low bit 3 marks ground short to battery.
// - Low bit 2 marks any thermal event.
// - High bit 7 marks any output-voltage event.
// - High bit 6 marks current limit or hiccup.
// - High bit 4 marks leaving current limit.
// - High bit 3 mirrors power not good live.
// - Reserved summary bits read as zero.
// - Thermal bit 7 marks 160C fault.
// - Thermal bit 6 warns at 135C, 20C hysteresis.
// - Thermal bit 3 marks warning release.
// - Writes take effect when the byte completes.
`timescale 1ns/100ps
`include "pmcs_params.svh"

module pmcs_regs
  import pmcs_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire pmcs_cmd_s                 cmd,
  input  wire pmcs_cond_s                cond,
  input  wire logic [`PMCS_TEMP_W-1:0]   die_temp_c,
  output logic                           conv_on,
  output logic [`PMCS_DAC_W-1:0]         dac_code,
  output logic                           alert_pin,
  output pmcs_rsp_s                      rsp
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic pmcs_op_is_on(input logic [`PMCS_CODE_W-1:0] op);
    return (op == `PMCS_OP_ON_A) || (op == `PMCS_OP_ON_B);
  endfunction

  function automatic logic pmcs_in_span(input logic [`PMCS_WORD_W-1:0] sp);
    return (sp >= `PMCS_SP_MIN) && (sp <= `PMCS_SP_MAX);
  endfunction

  function automatic logic [`PMCS_DAC_W-1:0] pmcs_dac_of(input logic [`PMCS_WORD_W-1:0] sp);
    logic [`PMCS_PROD_W-1:0] prod;
    logic [`PMCS_MV_W-1:0]   mv;
    logic [`PMCS_MV_W-1:0]   diff;
    prod = `PMCS_PROD_W'(sp) * `PMCS_PROD_W'(`PMCS_DAC_MULT);
    mv   = prod[`PMCS_PROD_W-1:`PMCS_DAC_SHIFT];
    diff = mv - `PMCS_DAC_OFFSET;
    if (mv < `PMCS_DAC_OFFSET) begin
      return '0;
    end else if (diff > `PMCS_DAC_MAX) begin
      return `PMCS_DAC_W'(`PMCS_DAC_MAX);
    end else begin
      return diff[`PMCS_DAC_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pmcs_state_s st_q;
  pmcs_state_s st_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pmcs_cond_s              live;
    pmcs_flags_s             lvl;
    pmcs_flags_s             edg;
    pmcs_flags_s             base;
    pmcs_flags_s             setv;
    logic                    clr;
    logic                    warn_n;
    logic [`PMCS_WORD_W-1:0] word;
    live   = st_q.sync2;
    lvl    = '0;
    edg    = '0;
    base   = '0;
    setv   = '0;
    clr    = 1'b0;
    warn_n = st_q.warn_live;
    word   = '0;
    st_d   = st_q;

    // Pin conditions pass two flip-flops before use.
    st_d.sync1 = cond;
    st_d.sync2 = st_q.sync1;

    clr = cmd.valid & cmd.write & (cmd.code == `PMCS_CMD_CLEAR);

    // Warning enters at threshold and releases below it minus hysteresis.
    if (die_temp_c >= `PMCS_OT_WARN_C) begin
      warn_n = 1'b1;
    end else if (die_temp_c < (`PMCS_OT_WARN_C - `PMCS_OT_HYST_C)) begin
      warn_n = 1'b0;
    end
    st_d.warn_live = warn_n;

    // Current-limit episode tracking for the exit event.
    st_d.cc_prev  = live.cc;
    st_d.hic_seen = live.hiccup | (st_q.hic_seen & ~(live.pg & ~live.cc));

    // Level conditions.
    lvl.ov   = live.ov;
    lvl.oc   = live.cc | live.peak | live.hiccup;
    lvl.gnd  = live.gnd_short;
    lvl.output_voltage_flag = live.ov | ~pmcs_in_span(st_q.sp);
    lvl.otf  = (die_temp_c >= `PMCS_OVERTEMP_FAULT_FLAG_C);
    lvl.otw  = warn_n;

    // Edge events are never lost to a simultaneous clear.
    edg.ccx = st_q.cc_prev & ~live.cc & ~live.hiccup & ~st_q.hic_seen;
    edg.otr = st_q.warn_live & ~warn_n;

    // Clear empties all flags but same-cycle edge events, persisting levels set again next cycle.
    base = clr ? pmcs_flags_s'('0) : st_q.flg;
    setv = pmcs_flags_s'((clr ? pmcs_flags_s'('0) : lvl) | edg);
    st_d.flg = pmcs_flags_s'(base | setv);

    // Alert rises on any newly set flag and drops on clear unless an edge event sets a flag in the same cycle.
    st_d.alert = (clr ? 1'b0 : st_q.alert) | (|(setv & ~base));

    st_d.conv_on = live.en & pmcs_op_is_on(st_q.op);
    st_d.dac     = pmcs_dac_of(st_q.sp);

    st_d.rsp = '0;
    if (cmd.valid) begin
      st_d.rsp.valid = 1'b1;
      if (cmd.write) begin
        case (cmd.code)
          `PMCS_CMD_OPERATION: begin
            st_d.op = cmd.data[`PMCS_CODE_W-1:0];
          end
          `PMCS_CMD_SETPOINT: begin
            st_d.sp = cmd.data;
          end
          `PMCS_CMD_CLEAR: begin
            st_d.rsp.err = 1'b0;
          end
          default: begin
            st_d.rsp.err = 1'b1;
          end
        endcase
      end else begin
        case (cmd.code)
          `PMCS_CMD_OPERATION: begin
            word[`PMCS_CODE_W-1:0] = st_q.op;
          end
          `PMCS_CMD_SETPOINT: begin
            word = st_q.sp;
          end
          `PMCS_CMD_SUMMARY: begin
            word[`PMCS_SUM_OV]    = st_q.flg.ov;
            word[`PMCS_SUM_OC_LO] = st_q.flg.oc;
            word[`PMCS_SUM_GND]   = st_q.flg.gnd;
            word[`PMCS_SUM_TEMP]  = st_q.flg.otf | st_q.flg.otw | st_q.flg.otr;
            word[`PMCS_SUM_OUTPUT_VOLTAGE_FLAG]  = st_q.flg.output_voltage_flag | st_q.flg.ov;
            word[`PMCS_SUM_OC_HI] = st_q.flg.oc;
            word[`PMCS_SUM_CCX]   = st_q.flg.ccx;
            word[`PMCS_SUM_PGN]   = ~live.pg;
          end
          `PMCS_CMD_THERMAL: begin
            word[`PMCS_TH_FAULT] = st_q.flg.otf;
            word[`PMCS_TH_WARN]  = st_q.flg.otw;
            word[`PMCS_TH_REL]   = st_q.flg.otr;
          end
          default: begin
            st_d.rsp.err = 1'b1;
          end
        endcase
        st_d.rsp.data = word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.op    <= `PMCS_OP_RESET;
      st_q.sp    <= `PMCS_SP_RESET;
      st_q.dac   <= `PMCS_DAC_AT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign conv_on   = st_q.conv_on;
  assign dac_code  = st_q.dac;
  assign alert_pin = st_q.alert;
  assign rsp       = st_q.rsp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking pmcs_cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  sequence clear_cmd_s;
    cmd.valid && cmd.write && (cmd.code == `PMCS_CMD_CLEAR);
  endsequence

  sequence op_on_write_s;
    cmd.valid && cmd.write && (cmd.code == `PMCS_CMD_OPERATION) &&
      pmcs_op_is_on(cmd.data[`PMCS_CODE_W-1:0]);
  endsequence

  sequence read_of_s(logic [`PMCS_CODE_W-1:0] code);
    cmd.valid && !cmd.write && (cmd.code == code);
  endsequence

  sequence write_of_s(logic [`PMCS_CODE_W-1:0] code);
    cmd.valid && cmd.write && (cmd.code == code);
  endsequence

  sequence warn_fall_s;
    st_q.warn_live ##1 !st_q.warn_live;
  endsequence

  op_turns_on_a: assert property (
    op_on_write_s ##1 st_q.sync2.en |=> conv_on)
    else $error("output did not turn on after on command");

  enable_priority_a: assert property (
    !st_q.sync2.en |=> !conv_on)
    else $error("output on while enable requests off");

  clear_flags_a: assert property (
    clear_cmd_s |=> !st_q.flg.ov && !st_q.flg.oc && !st_q.flg.gnd &&
                    !st_q.flg.otf && !st_q.flg.otw && !st_q.flg.output_voltage_flag)
    else $error("latched flag survived fault clear");

  alert_drop_a: assert property (
    clear_cmd_s |=> !alert_pin)
    else $error("alert still asserted after fault clear");

  fault_reset_a: assert property (
    clear_cmd_s ##1 (st_q.sync2.ov && !(cmd.valid && cmd.write && cmd.code == `PMCS_CMD_CLEAR))
      |=> st_q.flg.ov && alert_pin)
    else $error("persisting fault not set again with alert");

  clear_read_a: assert property (
    read_of_s(`PMCS_CMD_CLEAR) |=> rsp.valid && rsp.err)
    else $error("read of fault clear not refused");

  output_voltage_flag_span_a: assert property (
    !pmcs_in_span(st_q.sp) && !(cmd.valid && cmd.write && cmd.code == `PMCS_CMD_CLEAR)
      |=> st_q.flg.output_voltage_flag)
    else $error("setpoint out of span not flagged");

  dac_reset_a: assert property (
    st_q.sp == `PMCS_SP_RESET |=> dac_code == `PMCS_DAC_AT_RESET)
    else $error("reference code wrong for default setpoint");

  pg_mirror_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> rsp.valid && (rsp.data[`PMCS_SUM_PGN] == !$past(st_q.sync2.pg)))
    else $error("power not good bit does not mirror live state");

  reserved_zero_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> (rsp.data & `PMCS_SUM_RSV_MASK) == '0)
    else $error("reserved summary bit reads as one");

  cc_exit_a: assert property (
    st_q.sync2.hiccup |=> !$rose(st_q.flg.ccx))
    else $error("current limit exit flagged during hiccup");

  overtemp_fault_flag_a: assert property (
    (die_temp_c >= `PMCS_OVERTEMP_FAULT_FLAG_C) && !(cmd.valid && cmd.write && cmd.code == `PMCS_CMD_CLEAR)
      |=> st_q.flg.otf)
    else $error("over temperature fault not flagged");

  warn_release_a: assert property (
    warn_fall_s |-> st_q.flg.otr)
    else $error("warning release not flagged");

  sp_write_a: assert property (
    write_of_s(`PMCS_CMD_SETPOINT) |=> st_q.sp == $past(cmd.data))
    else $error("setpoint write did not land");

  op_write_a: assert property (
    write_of_s(`PMCS_CMD_OPERATION) |=> st_q.op == $past(cmd.data[`PMCS_CODE_W-1:0]))
    else $error("on off write did not land");

  op_off_a: assert property (
    !pmcs_op_is_on(st_q.op) |=> !conv_on)
    else $error("output on with an off command");

  enable_on_a: assert property (
    st_q.sync2.en && pmcs_op_is_on(st_q.op) |=> conv_on)
    else $error("output off although enabled and commanded on");

  dac_floor_a: assert property (
    st_q.sp == `PMCS_SP_MIN |=> dac_code == '0)
    else $error("reference code not zero at lowest setpoint");

  summary_ov_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> rsp.data[`PMCS_SUM_OV] == $past(st_q.flg.ov))
    else $error("summary over voltage bit wrong");

  summary_oc_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> rsp.data[`PMCS_SUM_OC_LO] == $past(st_q.flg.oc) &&
                                     rsp.data[`PMCS_SUM_OC_HI] == $past(st_q.flg.oc))
    else $error("summary current bits wrong");

  summary_gnd_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> rsp.data[`PMCS_SUM_GND] == $past(st_q.flg.gnd))
    else $error("summary ground short bit wrong");

  summary_temp_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=>
      rsp.data[`PMCS_SUM_TEMP] == $past(st_q.flg.otf | st_q.flg.otw | st_q.flg.otr))
    else $error("summary temperature bit wrong");

  summary_output_voltage_flag_a: assert property (
    read_of_s(`PMCS_CMD_SUMMARY) |=> rsp.data[`PMCS_SUM_OUTPUT_VOLTAGE_FLAG] == $past(st_q.flg.output_voltage_flag | st_q.flg.ov))
    else $error("summary output voltage bit wrong");

  thermal_read_a: assert property (
    read_of_s(`PMCS_CMD_THERMAL) |=> rsp.data[`PMCS_TH_FAULT] == $past(st_q.flg.otf) &&
                                     rsp.data[`PMCS_TH_WARN] == $past(st_q.flg.otw) &&
                                     rsp.data[`PMCS_TH_REL] == $past(st_q.flg.otr))
    else $error("thermal status bits wrong");

  warn_entry_a: assert property (
    die_temp_c >= `PMCS_OT_WARN_C |=> st_q.warn_live)
    else $error("warning not entered at threshold");

  warn_hyst_a: assert property (
    st_q.warn_live && (die_temp_c >= (`PMCS_OT_WARN_C - `PMCS_OT_HYST_C)) |=> st_q.warn_live)
    else $error("warning released inside hysteresis");

  latch_hold_a: assert property (
    st_q.flg.gnd && !(cmd.valid && cmd.write && cmd.code == `PMCS_CMD_CLEAR) |=> st_q.flg.gnd)
    else $error("latched flag lost without fault clear");

  ccx_source_a: assert property (
    $rose(st_q.flg.ccx) |-> $past(st_q.cc_prev))
    else $error("current limit exit flagged without current limit");

endmodule

// [bench/pmcs_host.sv]
`timescale 1ns/100ps
`include "pmcs_params.svh"

module pmcs_host
  import pmcs_pkg::*;
(
  input  wire logic      clk,
  output pmcs_cmd_s      cmd,
  input  wire pmcs_rsp_s rsp
);
  // ----
  // Command issue
  // ----
  initial cmd = '0;

  // Sends one complete command and takes the answer at the next edge.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic ok, output logic err, output logic [15:0] rd);
    @(posedge clk);
    #1;
    cmd = '{1'b1, w, c, d};
    @(posedge clk);
    #1;
    cmd = '{1'b0, ~w, ~c, ~d};
    ok = rsp.valid;
    err = rsp.err;
    rd = rsp.data;
  endtask

  // Fault clear only ever goes out as a write.
  task automatic clear_faults(output logic ok, output logic err);
    logic [15:0] unused;
    xfer(1'b1, `PMCS_CMD_CLEAR, 16'h0000, ok, err, unused);
  endtask
endmodule

// [bench/pmcs_regs_tb.sv]
`timescale 1ns/100ps
`include "pmcs_params.svh"

module pmcs_regs_tb
  import pmcs_pkg::*;
;
  logic        clk;
  logic        rst_n;
  pmcs_cmd_s   cmd;
  pmcs_cond_s  cond;
  logic [7:0]  die_temp_c;
  logic        conv_on;
  logic [10:0] dac_code;
  logic        alert_pin;
  pmcs_rsp_s   rsp;
  int          error_cnt;
  int          num_checks;
  logic        ok;
  logic        err;
  logic [15:0] rd;
  logic [7:0]  ops [4] = '{8'h00, 8'h01, 8'h02, 8'h80};
  logic        ons [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] sps [5] = '{16'h0400, 16'h55E1, 16'h03FF, 16'h55E2, 16'h1400};
  logic        vfl [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  pmcs_regs pmcs_regs_i (.clk(clk), .rst_n(rst_n), .cmd(cmd), .cond(cond), .die_temp_c(die_temp_c),
                         .conv_on(conv_on), .dac_code(dac_code), .alert_pin(alert_pin), .rsp(rsp));
  pmcs_host pmcs_host_i (.clk(clk), .cmd(cmd), .rsp(rsp));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----
  // Helpers
  // ----
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Runs one command; for reads d is the expected data.
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic e);
    logic [15:0] g;
    pmcs_host_i.xfer(w, c, d, ok, err, rd);
    g = (c == `PMCS_CMD_SUMMARY || c == `PMCS_CMD_SETPOINT) ? rd : {8'h00, rd[7:0]};
    chk("rsp_valid", 16'h0001, 16'(ok));
    chk("rsp_err", 16'(e), 16'(err));
    if (!w && !e) chk("read_data", d, g);
  endtask

  task automatic cl(input logic ea);
    pmcs_host_i.clear_faults(ok, err);
    chk("clear_alert", 16'h0000, 16'(alert_pin));
    tick(1);
    chk("alert_again", 16'(ea), 16'(alert_pin));
  endtask

  function automatic logic [15:0] dac_of(input logic [15:0] sp);
    int v;
    v = (int'(sp) * 100) / 1024 - 100;
    if (v < 0) v = 0;
    if (v > 2047) v = 2047;
    return 16'(v);
  endfunction

  initial begin
    #5000000;
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    end_of_test();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n = 1'b0;
    cond = '0;
    cond.en = 1'b1;
    cond.pg = 1'b1;
    die_temp_c = 8'h19;
    repeat (12) @(posedge clk);
    #1;
    chk("conv_on", 16'h0000, 16'(conv_on));
    chk("dac_code", dac_of(16'h1400), 16'(dac_code));
    chk("alert_pin", 16'h0000, 16'(alert_pin));
    rst_n = 1'b1;
    tick(4);
    chk("conv_on", 16'h0001, 16'(conv_on));
    acc(1'b0, `PMCS_CMD_OPERATION, 16'h0080, 1'b0);
    acc(1'b0, `PMCS_CMD_SETPOINT, 16'h1400, 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `PMCS_CMD_OPERATION, {8'h00, ops[i]}, 1'b0);
      tick(2);
      chk("conv_on", 16'(ons[i]), 16'(conv_on));
    end
    cond.en = 1'b0;
    tick(4);
    acc(1'b1, `PMCS_CMD_OPERATION, 16'h0001, 1'b0);
    tick(2);
    chk("conv_on", 16'h0000, 16'(conv_on));
    cond.en = 1'b1;
    tick(4);
    chk("conv_on", 16'h0001, 16'(conv_on));
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, `PMCS_CMD_SETPOINT, sps[i], 1'b0);
      acc(1'b0, `PMCS_CMD_SETPOINT, sps[i], 1'b0);
      tick(2);
      chk("dac_code", dac_of(sps[i]), 16'(dac_code));
      cl(vfl[i]);
      tick(2);
      acc(1'b0, `PMCS_CMD_SUMMARY, {vfl[i], 15'h0000}, 1'b0);
      chk("alert_pin", 16'(vfl[i]), 16'(alert_pin));
    end
    acc(1'b1, `PMCS_CMD_SUMMARY, 16'h0000, 1'b1);
    acc(1'b1, `PMCS_CMD_THERMAL, 16'h0000, 1'b1);
    acc(1'b0, `PMCS_CMD_CLEAR, 16'h0000, 1'b1);
    acc(1'b0, 8'h55, 16'h0000, 1'b1);
    cond.ov = 1'b1;
    tick(4);
    chk("alert_pin", 16'h0001, 16'(alert_pin));
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h8020, 1'b0);
    cl(1'b1);
    cond.ov = 1'b0;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h8020, 1'b0);
    cl(1'b0);
    cond.cc = 1'b1;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h4010, 1'b0);
    cond.cc = 1'b0;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h5010, 1'b0);
    cl(1'b0);
    cond.cc = 1'b1;
    cond.hiccup = 1'b1;
    tick(4);
    cond.cc = 1'b0;
    tick(4);
    cond.hiccup = 1'b0;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h4010, 1'b0);
    cl(1'b0);
    cond.gnd_short = 1'b1;
    tick(4);
    cond.gnd_short = 1'b0;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h0008, 1'b0);
    cl(1'b0);
    cond.peak = 1'b1;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h4010, 1'b0);
    cl(1'b1);
    cond.peak = 1'b0;
    tick(4);
    cl(1'b0);
    cond.pg = 1'b0;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h0800, 1'b0);
    pmcs_host_i.clear_faults(ok, err);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h0800, 1'b0);
    cond.pg = 1'b1;
    tick(4);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h0000, 1'b0);
    die_temp_c = 8'h9F;
    tick(3);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h0040, 1'b0);
    die_temp_c = 8'hA0;
    tick(3);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h00C0, 1'b0);
    acc(1'b0, `PMCS_CMD_SUMMARY, 16'h0004, 1'b0);
    die_temp_c = 8'h19;
    tick(3);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h00C8, 1'b0);
    cl(1'b0);
    tick(2);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h0000, 1'b0);
    die_temp_c = 8'h87;
    tick(3);
    die_temp_c = 8'h73;
    pmcs_host_i.clear_faults(ok, err);
    tick(3);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h0040, 1'b0);
    die_temp_c = 8'h72;
    tick(3);
    acc(1'b0, `PMCS_CMD_THERMAL, 16'h0048, 1'b0);
    end_of_test();
  end
endmodule
